/* rtl/status_defines.svh */
// constants for the measurement status summary registers
`ifndef STATUS_DEFINES_SVH
`define STATUS_DEFINES_SVH

`define STATUS_WIDTH 16
`define STATUS_RESET 16'h0000
`define ENABLE_RESET 16'h0000
`define STATUS_TOP_BIT 15

`define QS_POWER_BIT 3
`define QS_CAL_BIT 8
`define QS_SELFTEST_BIT 9
`define QS_DEFINED_MASK 16'h0308

`define OP_CAL_BIT 0
`define OP_FLAG_A_BIT 4
`define OP_TRIG_BIT 5
`define OP_SENSE_BIT 10
`define OP_LOWER_FAIL_BIT 11
`define OP_UPPER_FAIL_BIT 12
`define OP_DEFINED_MASK 16'h1c31

`define ERR_DATA_CORRUPT 16'hff1a
`define ERR_DATA_QUESTIONABLE 16'hff19

`define STB_QUALITY_BIT 3
`define STB_ACTIVITY_BIT 7

`endif

/* rtl/status_pkg.sv */
// types shared by the measurement status summary modules
package status_pkg;

    typedef enum logic [1:0] {
        SEL_QUALITY_COND,
        SEL_QUALITY_ENABLE,
        SEL_ACTIVITY_COND,
        SEL_ACTIVITY_ENABLE
    } cmd_sel_e;

    typedef struct packed {
        logic [15:0] word;
        logic meas_bad;
        logic cal_bad;
        logic cal_pushed;
    } quality_state_s;

    typedef struct packed {
        logic [15:0] word;
    } activity_state_s;

    typedef struct packed {
        logic [15:0] quality_enable;
        logic [15:0] activity_enable;
        logic [15:0] quality_status;
        logic [15:0] activity_status;
        logic stb_quality;
        logic stb_activity;
        logic rsp_valid;
        logic [15:0] rsp_data;
    } top_state_s;

endpackage

/* rtl/status_carrier_if.sv */
// carries the two condition words from the trackers to the top
`timescale 1ns/1ns
interface status_carrier_if;
    logic [15:0] quality_word;
    logic [15:0] activity_word;

    modport quality_src (output quality_word);
    modport activity_src (output activity_word);
    modport sink (input quality_word, input activity_word);
endinterface

/* rtl/quality_status_logic.sv */
// condition bits of the measurement quality status register
`timescale 1ns/1ns
`include "status_defines.svh"
module quality_status_logic (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // measurement events
    input wire logic meas_done,
    input wire logic meas_err_valid,
    input wire logic [15:0] meas_err_code,
    // zero and calibration events
    input wire logic cal_done,
    input wire logic cal_zero_err_a,
    input wire logic cal_zero_err_b,
    input wire logic cal_err_a,
    input wire logic cal_err_b,
    input wire logic err_queue_push,
    // self test
    input wire logic selftest_done,
    input wire logic selftest_pass,
    // condition word out
    status_carrier_if.quality_src carrier
);
    import status_pkg::*;

    quality_state_s q, d;
    logic meas_err_now;
    logic cal_err_now;

    assign meas_err_now = meas_err_valid &&
        (meas_err_code == `ERR_DATA_CORRUPT || meas_err_code == `ERR_DATA_QUESTIONABLE);
    assign cal_err_now = cal_zero_err_a | cal_zero_err_b | cal_err_a | cal_err_b;

    always_comb begin
        d = q;
        // errors are held until the measurement closes, so late ones still count
        if (meas_err_now) begin
            d.meas_bad = 1'b1;
        end
        if (meas_done) begin
            d.word[`QS_POWER_BIT] = q.meas_bad | meas_err_now;
            d.meas_bad = 1'b0;
        end
        if (cal_err_now) begin
            d.cal_bad = 1'b1;
        end
        if (err_queue_push) begin
            d.cal_pushed = 1'b1;
        end
        if (cal_done) begin
            if (q.cal_bad | cal_err_now) begin
                d.word[`QS_CAL_BIT] = 1'b1;
            end else if (!(q.cal_pushed | err_queue_push)) begin
                d.word[`QS_CAL_BIT] = 1'b0;
            end
            d.cal_bad = 1'b0;
            d.cal_pushed = 1'b0;
        end
        if (selftest_done) begin
            d.word[`QS_SELFTEST_BIT] = ~selftest_pass;
        end
        d.word = d.word & `QS_DEFINED_MASK;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign carrier.quality_word = q.word;
endmodule

/* rtl/activity_status_logic.sv */
// condition bits of the measurement activity status register
`timescale 1ns/1ns
`include "status_defines.svh"
module activity_status_logic (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // calibration activity
    input wire logic zero_once_command_start,
    input wire logic calibrate_once_command_start,
    input wire logic combined_zero_start,
    input wire logic cal_finish,
    // measurement and trigger
    input wire logic meas_start,
    input wire logic meas_done,
    input wire logic enter_wait_trigger,
    input wire logic enter_idle,
    input wire logic sensor_mem_reading,
    // limit test results, valid with meas_done
    input wire logic lower_limit_enabled,
    input wire logic channel_lower_fail,
    input wire logic window_lower_fail,
    input wire logic upper_limit_enabled,
    input wire logic channel_upper_fail,
    input wire logic window_upper_fail,
    // condition word out
    status_carrier_if.activity_src carrier
);
    import status_pkg::*;

    activity_state_s q, d;

    always_comb begin
        d = q;
        // a start in the finishing cycle wins, the new run must show
        if (zero_once_command_start | calibrate_once_command_start | combined_zero_start) begin
            d.word[`OP_CAL_BIT] = 1'b1;
        end else if (cal_finish) begin
            d.word[`OP_CAL_BIT] = 1'b0;
        end
        if (meas_start) begin
            d.word[`OP_FLAG_A_BIT] = 1'b1;
        end else if (meas_done) begin
            d.word[`OP_FLAG_A_BIT] = 1'b0;
        end
        if (enter_wait_trigger) begin
            d.word[`OP_TRIG_BIT] = 1'b1;
        end else if (enter_idle) begin
            d.word[`OP_TRIG_BIT] = 1'b0;
        end
        d.word[`OP_SENSE_BIT] = sensor_mem_reading;
        if (meas_done) begin
            d.word[`OP_LOWER_FAIL_BIT] = lower_limit_enabled &
                (channel_lower_fail | window_lower_fail);
            d.word[`OP_UPPER_FAIL_BIT] = upper_limit_enabled &
                (channel_upper_fail | window_upper_fail);
        end
        d.word = d.word & `OP_DEFINED_MASK;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign carrier.activity_word = q.word;
endmodule

/* rtl/measurement_status_summary_regs.sv */
// top of the measurement quality and activity status summary registers
`timescale 1ns/1ns
`include "status_defines.svh"
module measurement_status_summary_regs (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,

    // command port from the command interpreter
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire status_pkg::cmd_sel_e cmd_sel,
    input wire logic [15:0] cmd_wdata,

    // reply to the command interpreter
    output logic rsp_valid,
    output logic [15:0] rsp_data,

    // measurement events
    input wire logic meas_start,
    input wire logic meas_done,
    input wire logic meas_err_valid,
    input wire logic [15:0] meas_err_code,

    // zero and calibration events
    input wire logic zero_once_command_start,
    input wire logic calibrate_once_command_start,
    input wire logic combined_zero_start,
    input wire logic cal_finish,
    input wire logic cal_done,
    input wire logic cal_zero_err_a,
    input wire logic cal_zero_err_b,
    input wire logic cal_err_a,
    input wire logic cal_err_b,
    input wire logic err_queue_push,

    // self test
    input wire logic selftest_done,
    input wire logic selftest_pass,

    // trigger state and sensor memory
    input wire logic enter_wait_trigger,
    input wire logic enter_idle,
    input wire logic sensor_mem_reading,

    // limit test results, valid with meas_done
    input wire logic lower_limit_enabled,
    input wire logic channel_lower_fail,
    input wire logic window_lower_fail,
    input wire logic upper_limit_enabled,
    input wire logic channel_upper_fail,
    input wire logic window_upper_fail,

    // condition words
    output logic [15:0] quality_status,
    output logic [15:0] activity_status,

    // summary bits toward the status byte
    output logic [7:0] status_byte_part,
    output logic stb_quality_summary,
    output logic stb_activity_summary
);
    import status_pkg::*;

    top_state_s q, d;
    status_carrier_if carrier ();

    // one rule for both summaries: any enabled condition bit
    function automatic logic summary_of(
        input logic [15:0] cond,
        input logic [15:0] en
    );
        summary_of = |(cond & en);
    endfunction

    // the top bit of every word is forced low wherever it is stored
    function automatic logic [15:0] clip_word(input logic [15:0] w);
        logic [15:0] m;
        m = 16'hffff;
        m[`STATUS_TOP_BIT] = 1'b0;
        clip_word = w & m;
    endfunction

    quality_status_logic u_quality (
        .clk(clk),
        .reset_n(reset_n),
        .meas_done(meas_done),
        .meas_err_valid(meas_err_valid),
        .meas_err_code(meas_err_code),
        .cal_done(cal_done),
        .cal_zero_err_a(cal_zero_err_a),
        .cal_zero_err_b(cal_zero_err_b),
        .cal_err_a(cal_err_a),
        .cal_err_b(cal_err_b),
        .err_queue_push(err_queue_push),
        .selftest_done(selftest_done),
        .selftest_pass(selftest_pass),
        .carrier(carrier.quality_src)
    );

    activity_status_logic u_activity (
        .clk(clk),
        .reset_n(reset_n),
        .zero_once_command_start(zero_once_command_start),
        .calibrate_once_command_start(calibrate_once_command_start),
        .combined_zero_start(combined_zero_start),
        .cal_finish(cal_finish),
        .meas_start(meas_start),
        .meas_done(meas_done),
        .enter_wait_trigger(enter_wait_trigger),
        .enter_idle(enter_idle),
        .sensor_mem_reading(sensor_mem_reading),
        .lower_limit_enabled(lower_limit_enabled),
        .channel_lower_fail(channel_lower_fail),
        .window_lower_fail(window_lower_fail),
        .upper_limit_enabled(upper_limit_enabled),
        .channel_upper_fail(channel_upper_fail),
        .window_upper_fail(window_upper_fail),
        .carrier(carrier.activity_src)
    );

    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;

        // mirror the condition words so every output leaves a local flop
        d.quality_status = clip_word(carrier.quality_word);
        d.activity_status = clip_word(carrier.activity_word);

        // enable masks: only a write command changes them
        if (cmd_valid && cmd_write) begin
            case (cmd_sel)
                SEL_QUALITY_ENABLE: begin
                    d.quality_enable = clip_word(cmd_wdata);
                end
                SEL_ACTIVITY_ENABLE: begin
                    d.activity_enable = clip_word(cmd_wdata);
                end
                default: begin
                    // condition words are read only; the write is dropped
                    d.quality_enable = q.quality_enable;
                end
            endcase
        end

        // every command gets one reply; a write echoes what was stored
        if (cmd_valid) begin
            d.rsp_valid = 1'b1;
            case (cmd_sel)
                SEL_QUALITY_COND: begin
                    d.rsp_data = q.quality_status;
                end
                SEL_QUALITY_ENABLE: begin
                    d.rsp_data = d.quality_enable;
                end
                SEL_ACTIVITY_COND: begin
                    d.rsp_data = q.activity_status;
                end
                SEL_ACTIVITY_ENABLE: begin
                    d.rsp_data = d.activity_enable;
                end
                default: begin
                    d.rsp_data = 16'h0000;
                end
            endcase
        end

        // summaries use the mirrored words, so they trail them by nothing:
        // both are taken from the same next values that the mirror flops load
        d.stb_quality = summary_of(d.quality_status, d.quality_enable);
        d.stb_activity = summary_of(d.activity_status, d.activity_enable);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q.quality_enable <= `ENABLE_RESET;
            q.activity_enable <= `ENABLE_RESET;
            q.quality_status <= `STATUS_RESET;
            q.activity_status <= `STATUS_RESET;
            q.stb_quality <= 1'b0;
            q.stb_activity <= 1'b0;
            q.rsp_valid <= 1'b0;
            q.rsp_data <= 16'h0000;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign rsp_valid = q.rsp_valid;
    assign rsp_data = q.rsp_data;
    assign quality_status = q.quality_status;
    assign activity_status = q.activity_status;
    assign stb_quality_summary = q.stb_quality;
    assign stb_activity_summary = q.stb_activity;

    // only the two summary positions are owned here; the rest of the
    // status byte is assembled elsewhere and reads zero from this block
    generate
        genvar i;
        for (i = 0; i < 8; i = i + 1) begin : g_stb
            if (i == `STB_QUALITY_BIT) begin : g_q
                assign status_byte_part[i] = q.stb_quality;
            end else if (i == `STB_ACTIVITY_BIT) begin : g_a
                assign status_byte_part[i] = q.stb_activity;
            end else begin : g_z
                assign status_byte_part[i] = 1'b0;
            end
        end
    endgenerate
endmodule

/* tb/status_summary_sva.sv */
// assertions on the ports of the measurement status summary registers
`timescale 1ns/1ns
`include "status_defines.svh"
module status_summary_sva (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // command port
    input wire logic cmd_valid,
    input wire logic rsp_valid,
    // events
    input wire logic meas_start,
    input wire logic meas_done,
    input wire logic meas_err_valid,
    input wire logic [15:0] meas_err_code,
    input wire logic zero_once_command_start,
    input wire logic calibrate_once_command_start,
    input wire logic combined_zero_start,
    input wire logic cal_finish,
    input wire logic cal_done,
    input wire logic cal_zero_err_a,
    input wire logic cal_zero_err_b,
    input wire logic cal_err_a,
    input wire logic cal_err_b,
    input wire logic selftest_done,
    input wire logic selftest_pass,
    input wire logic enter_wait_trigger,
    input wire logic enter_idle,
    input wire logic sensor_mem_reading,
    input wire logic lower_limit_enabled,
    input wire logic channel_lower_fail,
    input wire logic window_lower_fail,
    input wire logic upper_limit_enabled,
    input wire logic channel_upper_fail,
    input wire logic window_upper_fail,
    // outputs watched
    input wire logic [15:0] quality_status,
    input wire logic [15:0] activity_status,
    input wire logic [7:0] status_byte_part,
    input wire logic stb_quality_summary,
    input wire logic stb_activity_summary
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic any_start;
    logic lower_bad;
    logic upper_bad;
    logic cal_bad;
    assign any_start = zero_once_command_start | calibrate_once_command_start | combined_zero_start;
    assign lower_bad = lower_limit_enabled & (channel_lower_fail | window_lower_fail);
    assign upper_bad = upper_limit_enabled & (channel_upper_fail | window_upper_fail);
    assign cal_bad = cal_zero_err_a | cal_zero_err_b | cal_err_a | cal_err_b;

    a_top_bit_zero: assert property (!quality_status[15] && !activity_status[15])
        else $error("top status bit set");
    a_undefined_bits_zero: assert property (((quality_status & ~16'h0308) == 16'h0000)
        && ((activity_status & ~16'h1c31) == 16'h0000))
        else $error("undefined status bit set");
    a_reply_one_cycle: assert property (rsp_valid == $past(cmd_valid))
        else $error("reply not one cycle after command");
    a_flag_a_rise: assert property (meas_start |-> ##2 activity_status[4])
        else $error("flag_a bit not set");
    a_flag_a_fall: assert property (meas_done && !meas_start |-> ##2 !activity_status[4])
        else $error("flag_a bit not cleared");
    a_calibrating_set: assert property (any_start |-> ##2 activity_status[0])
        else $error("calibrating bit not set");
    a_calibrating_clear: assert property (cal_finish && !any_start |-> ##2 !activity_status[0])
        else $error("calibrating bit not cleared");
    a_trigger_wait: assert property (enter_wait_trigger |-> ##2 activity_status[5])
        else $error("trigger wait bit not set");
    a_trigger_idle: assert property (enter_idle && !enter_wait_trigger |-> ##2 !activity_status[5])
        else $error("trigger wait bit not cleared");
    a_sense_follows: assert property (sensor_mem_reading |-> ##2 activity_status[10])
        else $error("sensor read bit not set");
    a_sense_drops: assert property (!sensor_mem_reading |-> ##2 !activity_status[10])
        else $error("sensor read bit not cleared");
    a_lower_limit: assert property (meas_done |-> ##2 activity_status[11] == $past(lower_bad, 2))
        else $error("lower limit bit wrong");
    a_upper_limit: assert property (meas_done |-> ##2 activity_status[12] == $past(upper_bad, 2))
        else $error("upper limit bit wrong");
    a_power_error_set: assert property (meas_done && meas_err_valid
        && (meas_err_code == 16'hff1a || meas_err_code == 16'hff19) |-> ##2 quality_status[3])
        else $error("power quality bit not set");
    a_cal_error_set: assert property (cal_done && cal_bad |-> ##2 quality_status[8])
        else $error("calibration quality bit not set");
    a_selftest_result: assert property (selftest_done |-> ##2 quality_status[9] == !$past(selftest_pass, 2))
        else $error("self test bit wrong");
    a_status_byte_map: assert property (status_byte_part
        == {stb_activity_summary, 3'b000, stb_quality_summary, 3'b000})
        else $error("status byte bits misplaced");
    a_summary_needs_bits: assert property ((!stb_quality_summary || quality_status != 16'h0000)
        && (!stb_activity_summary || activity_status != 16'h0000))
        else $error("summary set with no status bit");
endmodule

/* tb/measurement_status_summary_regs_tb.sv */
// self-checking bench for the measurement status summary registers
`timescale 1ns/1ns
module measurement_status_summary_regs_tb;
    import status_pkg::*;
    logic clk, reset_n, cmd_valid, cmd_write, rsp_valid;
    cmd_sel_e cmd_sel;
    logic [15:0] cmd_wdata, rsp_data, meas_err_code, quality_status, activity_status, rd_q;
    logic meas_start, meas_done, meas_err_valid, zero_once_command_start;
    logic calibrate_once_command_start, combined_zero_start, cal_finish, cal_done;
    logic cal_zero_err_a, cal_zero_err_b, cal_err_a, cal_err_b, err_queue_push;
    logic selftest_done, selftest_pass, enter_wait_trigger, enter_idle, sensor_mem_reading;
    logic lower_limit_enabled, channel_lower_fail, window_lower_fail;
    logic upper_limit_enabled, channel_upper_fail, window_upper_fail;
    logic [7:0] status_byte_part;
    logic stb_quality_summary, stb_activity_summary;
    int err_total, checks;

    measurement_status_summary_regs u_dut (.*);

    always #5 clk = ~clk;

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // pulses last exactly one sampled edge, then the word is looked at once it has landed
    task automatic fire;
        @(posedge clk);
        {meas_start, meas_done, meas_err_valid, zero_once_command_start,
            calibrate_once_command_start, combined_zero_start, cal_finish, cal_done,
            cal_zero_err_a, cal_zero_err_b, cal_err_a, cal_err_b, err_queue_push,
            selftest_done, enter_wait_trigger, enter_idle, cmd_valid} <= '0;
        @(posedge clk);
        #1;
    endtask

    task automatic cmd(input cmd_sel_e sel, input logic wr, input logic [15:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_sel <= sel;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        cmp("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
        rd_q = rsp_data;
    endtask

    task automatic t_reset;
        cmp("quality", 16'h0000, quality_status);
        cmp("activity", 16'h0000, activity_status);
        cmd(SEL_QUALITY_ENABLE, 1'b0, 16'h0000);
        cmp("quality mask", 16'h0000, rd_q);
    endtask

    task automatic t_meas;
        @(posedge clk);
        meas_start <= 1'b1;
        fire;
        cmp("flag_a", 16'h0010, activity_status);
        @(posedge clk);
        {meas_done, upper_limit_enabled, channel_upper_fail} <= 3'b111;
        {lower_limit_enabled, window_lower_fail} <= 2'b11;
        fire;
        cmp("limits failed", 16'h1800, activity_status);
        @(posedge clk);
        {meas_done, lower_limit_enabled, channel_upper_fail} <= 3'b100;
        fire;
        cmp("limits passed", 16'h0000, activity_status);
        @(posedge clk);
        {meas_done, lower_limit_enabled, channel_lower_fail, window_upper_fail} <= 4'b1111;
        fire;
        cmp("limits failed", 16'h1800, activity_status);
        @(posedge clk);
        {meas_done, upper_limit_enabled, lower_limit_enabled} <= 3'b100;
        fire;
        cmp("limits off", 16'h0000, activity_status);
    endtask

    task automatic t_power;
        logic [15:0] codes[4] = '{16'hff19, 16'hff00, 16'hff1a, 16'h0000};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            meas_err_valid <= (codes[i] != 16'h0000);
            meas_err_code <= codes[i];
            meas_done <= 1'b1;
            fire;
            cmp("power quality", (i % 2) ? 16'h0000 : 16'h0008, quality_status);
        end
    endtask

    task automatic t_cal;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            {zero_once_command_start, calibrate_once_command_start, combined_zero_start} <= 3'b001 << i;
            fire;
            cmp("calibrating", 16'h0001, activity_status);
            @(posedge clk);
            cal_finish <= 1'b1;
            fire;
            cmp("calibrating", 16'h0000, activity_status);
        end
        // errors arrive ahead of the result moment and must be held until it
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {cal_zero_err_a, cal_zero_err_b, cal_err_a, cal_err_b} <= 4'b0001 << i;
            fire;
            @(posedge clk);
            cal_done <= 1'b1;
            fire;
            cmp("cal quality", 16'h0100, quality_status);
            @(posedge clk);
            {err_queue_push, cal_done} <= 2'b11;
            fire;
            cmp("cal pushed", 16'h0100, quality_status);
            @(posedge clk);
            cal_done <= 1'b1;
            fire;
            cmp("cal clean", 16'h0000, quality_status);
        end
        // an error in the result cycle itself still counts
        @(posedge clk);
        {cal_err_b, cal_done} <= 2'b11;
        fire;
        cmp("cal same cycle", 16'h0100, quality_status);
        @(posedge clk);
        cal_done <= 1'b1;
        fire;
        cmp("cal clean", 16'h0000, quality_status);
    endtask

    task automatic t_misc;
        @(posedge clk);
        {selftest_done, selftest_pass, enter_wait_trigger, sensor_mem_reading} <= 4'b1011;
        fire;
        cmp("self test", 16'h0200, quality_status);
        cmp("trigger sense", 16'h0420, activity_status);
        cmd(SEL_QUALITY_COND, 1'b0, 16'h0000);
        cmp("quality read", 16'h0200, rd_q);
        cmd(SEL_QUALITY_ENABLE, 1'b1, 16'h0008);
        cmp("quality summary", 16'h0000, {15'h0000, stb_quality_summary});
        cmd(SEL_QUALITY_ENABLE, 1'b1, 16'hffff);
        cmp("mask echo", 16'h7fff, rd_q);
        cmd(SEL_ACTIVITY_ENABLE, 1'b1, 16'h0400);
        cmp("status byte", 16'h0088, {8'h00, status_byte_part});
        cmp("activity summary", 16'h0001, {15'h0000, stb_activity_summary});
        cmd(SEL_ACTIVITY_COND, 1'b1, 16'hffff);
        cmp("cond write ignored", 16'h0420, rd_q);
        @(posedge clk);
        {selftest_done, selftest_pass, enter_idle, sensor_mem_reading} <= 4'b1110;
        fire;
        cmp("all cleared", 16'h0000, quality_status | activity_status);
        cmp("status byte", 16'h0000, {8'h00, status_byte_part});
    endtask

    task automatic conclude;
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {cmd_valid, cmd_write, cmd_wdata, meas_start, meas_done, meas_err_valid, meas_err_code,
            zero_once_command_start, calibrate_once_command_start, combined_zero_start,
            cal_finish, cal_done, cal_zero_err_a, cal_zero_err_b, cal_err_a, cal_err_b,
            err_queue_push, selftest_done, selftest_pass, enter_wait_trigger, enter_idle,
            sensor_mem_reading, lower_limit_enabled, channel_lower_fail, window_lower_fail,
            upper_limit_enabled, channel_upper_fail, window_upper_fail} = '0;
        cmd_sel = SEL_QUALITY_COND;
        err_total = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        t_reset;
        t_meas;
        t_power;
        t_cal;
        t_misc;
        conclude;
    end

    // the whole sequence needs about 130 cycles
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        conclude;
    end
endmodule

bind measurement_status_summary_regs status_summary_sva u_sva (.*);
